//--- include/srcin_defs.svh
// Constants of the serial audio input port receiver
`ifndef SRCIN_DEFS_SVH
`define SRCIN_DEFS_SVH

// Word format codes of a converter
`define SRCIN_FMT_LSB16      3'h0
`define SRCIN_FMT_LSB20      3'h1
`define SRCIN_FMT_MSB24      3'h2
`define SRCIN_FMT_I2S        3'h3
`define SRCIN_FMT_LSB24      3'h4
`define SRCIN_FMT_TDM_MSB    3'h5
`define SRCIN_FMT_TDM_I2S    3'h6

// Register byte addresses
`define SRCIN_ADDR_FMT_LO    12'h000
`define SRCIN_ADDR_FMT_HI    12'h004
`define SRCIN_ADDR_STATUS    12'h008

// Format field layout: field n at bits 10*(n+1)+2 .. 10*(n+1)
`define SRCIN_FMT_STEP       10
`define SRCIN_FMT_MASK       48'h0701_c070_1c00
`define SRCIN_FMT_RESET      48'h0000_0000_0000

// Status word fields
`define SRCIN_ST_SYNC        12
`define SRCIN_ST_CTL         13
`define SRCIN_ST_RUN         14

// Bit positions counted from the start of a word or frame
`define SRCIN_POS_MSB24_END  8'h17
`define SRCIN_POS_I2S24_END  8'h18
`define SRCIN_POS_I2S16_END  8'h0f
`define SRCIN_SLOT_END       5'h17

// Timing
`define SRCIN_CLK_NS         100
`define SRCIN_PD_MIN_NS      150
`define SRCIN_PD_CYC  ((`SRCIN_PD_MIN_NS + `SRCIN_CLK_NS - 1) / `SRCIN_CLK_NS)

`endif

//--- include/srcin_pkg.sv
// Types and shared helpers of the serial audio input port receiver
`include "srcin_defs.svh"
package srcin_pkg;

	// State of one serial lane
	typedef struct packed {
		logic [2:0]  bclk_s;
		logic        bclk_f;
		logic [2:0]  lr_s;
		logic        lr_f;
		logic [2:0]  d_s;
		logic        d_f;
		logic [31:0] sh;
		logic        lr_prev;
		logic [7:0]  pos;
		logic [23:0] sample;
		logic [2:0]  tag;
		logic        valid;
	} srcin_lane_st_t;

	// State of the receiver top
	typedef struct packed {
		logic [2:0]      pd_s;
		logic            pd_f;
		logic [2:0]      sel_s;
		logic            sel_f;
		logic [2:0]      ctl_s;
		logic            ctl_f;
		logic [2:0][2:0] fp_s;
		logic [2:0]      fp_f;
		logic [2:0]      pin_fmt;
		logic [1:0]      pd_cnt;
		logic            run;
		logic [47:0]     fmt_vec;
		logic [31:0]     prdata;
		logic            pslverr;
	} srcin_top_st_t;

	// Filtered pin level: moves once second and third stage agree
	function automatic logic filt(input logic s2, input logic s3,
		input logic f);
		filt = (s2 == s3) ? s2 : f;
	endfunction

	function automatic logic is_tdm(input logic [2:0] fmt);
		is_tdm = (fmt >= `SRCIN_FMT_TDM_MSB);
	endfunction

	function automatic logic is_i2s(input logic [2:0] fmt);
		is_i2s = (fmt == `SRCIN_FMT_I2S) || (fmt >= `SRCIN_FMT_TDM_I2S);
	endfunction

	// Format field of converter n out of the format vector
	function automatic logic [2:0] fmt_field(input logic [47:0] v,
		input int n);
		fmt_field = v[`SRCIN_FMT_STEP * (n + 1) +: 3];
	endfunction

	// Stereo half: tag 0 left, 1 right
	function automatic logic [2:0] stereo_tag(input logic lr,
		input logic i2s);
		stereo_tag = {2'h0, i2s ? lr : ~lr};
	endfunction

endpackage

//--- include/srcin_lane_if.sv
// Carrier between the receiver top and one serial lane
`timescale 1ns/1ns
interface srcin_lane_if;
	logic        bclk;
	logic        lrck;
	logic        sdata;
	logic [2:0]  fmt;
	logic        en;
	logic [23:0] sample;
	logic [2:0]  tag;
	logic        valid;

	modport lane (
		input  bclk, lrck, sdata, fmt, en,
		output sample, tag, valid
	);
	modport ctl (
		output bclk, lrck, sdata, fmt, en,
		input  sample, tag, valid
	);
endinterface

//--- rtl/srcin_lane.sv
// One serial audio lane: pin sampling, word framing and sample capture
`timescale 1ns/1ns
`include "srcin_defs.svh"
module srcin_lane (
	input  wire logic i_clock,
	input  wire logic i_resetn,
	srcin_lane_if.lane lane_io
);
	srcin_pkg::srcin_lane_st_t st_reg;
	srcin_pkg::srcin_lane_st_t st_next;
	logic                      edge_rise;
	logic                      tdm;
	logic                      i2s;
	logic                      trans;
	logic                      start;
	logic [31:0]               shn;
	logic [7:0]                posn;
	logic [7:0]                rel;

	// ********************************************
	// Framing and capture
	// ********************************************
	// Bit clock edges are found by our own clock, so pins pass 3 stages
	always_comb begin
		st_next = st_reg;
		tdm = srcin_pkg::is_tdm(lane_io.fmt);
		i2s = srcin_pkg::is_i2s(lane_io.fmt);
		st_next.bclk_s = {st_reg.bclk_s[1:0], lane_io.bclk};
		st_next.lr_s = {st_reg.lr_s[1:0], lane_io.lrck};
		st_next.d_s = {st_reg.d_s[1:0], lane_io.sdata};
		st_next.bclk_f = srcin_pkg::filt(st_reg.bclk_s[1],
			st_reg.bclk_s[2], st_reg.bclk_f);
		st_next.lr_f = srcin_pkg::filt(st_reg.lr_s[1], st_reg.lr_s[2],
			st_reg.lr_f);
		st_next.d_f = srcin_pkg::filt(st_reg.d_s[1], st_reg.d_s[2],
			st_reg.d_f);
		edge_rise = st_next.bclk_f & ~st_reg.bclk_f;
		shn = {st_reg.sh[30:0], st_next.d_f};
		trans = st_next.lr_f ^ st_reg.lr_prev;
		// TDM frames open on one frame clock edge only
		start = tdm ? (i2s ? (st_reg.lr_prev & ~st_next.lr_f)
			: (~st_reg.lr_prev & st_next.lr_f)) : trans;
		posn = start ? 8'h00 : st_reg.pos + 8'h01;
		rel = (tdm && i2s) ? posn - 8'h01 : posn;
		st_next.valid = 1'b0;
		if (edge_rise) begin
			st_next.sh = shn;
			st_next.lr_prev = st_next.lr_f;
			st_next.pos = posn;
			case (lane_io.fmt)
				`SRCIN_FMT_LSB16, `SRCIN_FMT_LSB20, `SRCIN_FMT_LSB24: begin
					// Word ends just before the frame clock turns
					if (trans) begin
						st_next.valid = 1'b1;
						st_next.tag = srcin_pkg::stereo_tag(st_reg.lr_prev, 1'b0);
						if (lane_io.fmt == `SRCIN_FMT_LSB16)
							st_next.sample = {st_reg.sh[15:0], 8'h00};
						else if (lane_io.fmt == `SRCIN_FMT_LSB20)
							st_next.sample = {st_reg.sh[19:0], 4'h0};
						else
							st_next.sample = st_reg.sh[23:0];
					end
				end
				`SRCIN_FMT_MSB24: begin
					if (posn == `SRCIN_POS_MSB24_END) begin
						st_next.valid = 1'b1;
						st_next.sample = shn[23:0];
						st_next.tag = srcin_pkg::stereo_tag(st_next.lr_f, 1'b0);
					end
				end
				`SRCIN_FMT_I2S: begin
					if (posn == `SRCIN_POS_I2S24_END) begin
						st_next.valid = 1'b1;
						st_next.sample = shn[23:0];
						st_next.tag = srcin_pkg::stereo_tag(st_next.lr_f, 1'b1);
					end else if (trans && st_reg.pos == `SRCIN_POS_I2S16_END) begin
						// 32fs: last bit lands on the turning edge
						st_next.valid = 1'b1;
						st_next.sample = {shn[15:0], 8'h00};
						st_next.tag = srcin_pkg::stereo_tag(st_reg.lr_prev, 1'b1);
					end
				end
				default: begin
					if (tdm && rel[4:0] == `SRCIN_SLOT_END) begin
						st_next.valid = 1'b1;
						st_next.sample = shn[23:0];
						st_next.tag = rel[7:5];
					end
				end
			endcase
		end
		if (!lane_io.en) begin
			st_next.sh = 32'h0000_0000;
			st_next.pos = 8'h00;
			st_next.lr_prev = 1'b0;
			st_next.valid = 1'b0;
		end
	end

	// ********************************************
	// State register
	// ********************************************
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign lane_io.sample = st_reg.sample;
	assign lane_io.tag = st_reg.tag;
	assign lane_io.valid = st_reg.valid;

	// ********************************************
	// Checks
	// ********************************************
	sample_edge_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.valid |-> $past(edge_rise))
		else $error("Sample delivered without a bit clock edge");
	msb_first_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		edge_rise && lane_io.en |=> st_reg.sh[31:1] == $past(st_reg.sh[30:0]))
		else $error("Shift register not filling MSB first");
	stereo_tag_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.valid && !srcin_pkg::is_tdm(lane_io.fmt) |->
		st_reg.tag[2:1] == 2'h0)
		else $error("Stereo sample carries a slot tag");
	short_pad_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.valid && $past(lane_io.fmt) == `SRCIN_FMT_LSB16 |->
		st_reg.sample[7:0] == 8'h00)
		else $error("16-bit sample not padded in low byte");
endmodule

//--- rtl/srcin_top.sv
// Serial audio input port receiver for a four-converter rate converter
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "srcin_defs.svh"

module srcin_top (
	input  wire logic              i_clock,
	input  wire logic              i_resetn,
	input  wire logic              i_power_down_n,
	input  wire logic              i_sync_select,
	input  wire logic              i_control_select,
	input  wire logic [2:0]        i_format_pins,
	input  wire logic [3:0]        i_input_bit_clock,
	input  wire logic [3:0]        i_input_frame_clock,
	input  wire logic [3:0]        i_serial_data_in,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic      [3:0]        o_sample_valid,
	output logic      [3:0][23:0]  o_sample_data,
	output logic      [3:0][2:0]   o_sample_tag
);
	srcin_pkg::srcin_top_st_t st_reg;
	srcin_pkg::srcin_top_st_t st_next;
	logic [3:0][2:0]          eff_fmt;
	logic [3:0]               lane_en;
	logic [3:0]               lane_bclk;
	logic [3:0]               lane_lrck;
	logic [3:0]               lane_sdata;
	logic                     tdm_sync;
	logic                     apb_setup;
	logic                     apb_access;
	logic                     addr_hit;
	logic [31:0]              rd_word;
	logic [11:0]              status_fmt;

	// ********************************************
	// Format selection and lane routing
	// ********************************************
	// Effective format per converter
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (st_reg.ctl_f)
				eff_fmt[i] = srcin_pkg::fmt_field(st_reg.fmt_vec, i);
			else
				eff_fmt[i] = st_reg.pin_fmt;
		end
	end

	assign tdm_sync = ~st_reg.sel_f & srcin_pkg::is_tdm(eff_fmt[0]);

	// Clock pair choice; lanes 2-4 are switched off while synchronous and lane 1 uses TDM
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_bclk[i] = st_reg.sel_f ? i_input_bit_clock[i]
				: i_input_bit_clock[0];
			lane_lrck[i] = st_reg.sel_f ? i_input_frame_clock[i]
				: i_input_frame_clock[0];
			lane_sdata[i] = i_serial_data_in[i];
			lane_en[i] = st_reg.run & ~(tdm_sync && i != 0);
		end
	end

	// ********************************************
	// Lanes
	// ********************************************
	// One receiver per serial data input
	generate
		for (genvar g = 0; g < 4; g++) begin : g_lane
			srcin_lane_if lane_bus ();

			assign lane_bus.bclk = lane_bclk[g];
			assign lane_bus.lrck = lane_lrck[g];
			assign lane_bus.sdata = lane_sdata[g];
			assign lane_bus.fmt = eff_fmt[g];
			assign lane_bus.en = lane_en[g];
			assign o_sample_valid[g] = lane_bus.valid;
			assign o_sample_data[g] = lane_bus.sample;
			assign o_sample_tag[g] = lane_bus.tag;

			srcin_lane i_srcin_lane (
				.i_clock  (i_clock),
				.i_resetn (i_resetn),
				.lane_io  (lane_bus)
			);
		end
	endgenerate

	// ********************************************
	// Register bus
	// ********************************************
	// Zero wait states: every access phase completes at once
	assign apb_setup = i_psel & ~i_penable;
	assign apb_access = i_psel & i_penable;
	assign o_pready = apb_access;
	assign o_pslverr = apb_access & st_reg.pslverr;
	assign o_prdata = st_reg.prdata;
	assign addr_hit = (i_paddr == `SRCIN_ADDR_FMT_LO)
		|| (i_paddr == `SRCIN_ADDR_FMT_HI)
		|| (i_paddr == `SRCIN_ADDR_STATUS);

	// Status shows the formats the lanes really use
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			status_fmt[3 * i +: 3] = eff_fmt[i];
		end
	end

	// Read word, taken into a register during the setup phase
	always_comb begin
		rd_word = 32'h0000_0000;
		case (i_paddr)
			`SRCIN_ADDR_FMT_LO: rd_word = st_reg.fmt_vec[31:0];
			`SRCIN_ADDR_FMT_HI: rd_word = {16'h0000, st_reg.fmt_vec[47:32]};
			`SRCIN_ADDR_STATUS: begin
				rd_word[11:0] = status_fmt;
				rd_word[`SRCIN_ST_SYNC] = st_reg.sel_f;
				rd_word[`SRCIN_ST_CTL] = st_reg.ctl_f;
				rd_word[`SRCIN_ST_RUN] = st_reg.run;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ********************************************
	// Control state
	// ********************************************
	// Pin filters, power down sequencing, format capture and writes
	always_comb begin
		st_next = st_reg;
		st_next.pd_s = {st_reg.pd_s[1:0], i_power_down_n};
		st_next.sel_s = {st_reg.sel_s[1:0], i_sync_select};
		st_next.ctl_s = {st_reg.ctl_s[1:0], i_control_select};
		st_next.pd_f = srcin_pkg::filt(st_reg.pd_s[1], st_reg.pd_s[2],
			st_reg.pd_f);
		st_next.sel_f = srcin_pkg::filt(st_reg.sel_s[1], st_reg.sel_s[2],
			st_reg.sel_f);
		st_next.ctl_f = srcin_pkg::filt(st_reg.ctl_s[1], st_reg.ctl_s[2],
			st_reg.ctl_f);
		for (int b = 0; b < 3; b++) begin
			st_next.fp_s[b] = {st_reg.fp_s[b][1:0], i_format_pins[b]};
			st_next.fp_f[b] = srcin_pkg::filt(st_reg.fp_s[b][1],
				st_reg.fp_s[b][2], st_reg.fp_f[b]);
		end
		if (!st_reg.pd_f) begin
			st_next.run = 1'b0;
			st_next.pd_cnt = 2'(`SRCIN_PD_CYC);
			st_next.fmt_vec = `SRCIN_FMT_RESET;
		end else if (st_reg.pd_cnt != 2'h0) begin
			// Keeps the lanes quiet a little past the release
			st_next.pd_cnt = st_reg.pd_cnt - 2'h1;
		end else begin
			st_next.run = 1'b1;
		end
		if (st_next.run && !st_reg.run)
			st_next.pin_fmt = st_reg.fp_f;
		// Read data and error are settled before the access phase
		if (apb_setup) begin
			st_next.prdata = rd_word;
			st_next.pslverr = ~addr_hit;
		end
		// Writes are lost while powered down, the fields are in reset
		if (apb_access && i_pwrite && st_reg.pd_f) begin
			case (i_paddr)
				`SRCIN_ADDR_FMT_LO:
					st_next.fmt_vec[31:0] = i_pwdata & 32'(`SRCIN_FMT_MASK);
				`SRCIN_ADDR_FMT_HI:
					st_next.fmt_vec[47:32] = i_pwdata[15:0]
						& 16'(`SRCIN_FMT_MASK >> 32);
				default: st_next.fmt_vec = st_reg.fmt_vec;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ********************************************
	// Checks
	// ********************************************
	sync_clock_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!st_reg.sel_f |->
		lane_bclk == {4{i_input_bit_clock[0]}}
		&& lane_lrck == {4{i_input_frame_clock[0]}})
		else $error("Synchronous lanes not on clock pair one");
	async_clock_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.sel_f |->
		lane_bclk == i_input_bit_clock && lane_lrck == i_input_frame_clock)
		else $error("Asynchronous lane not on its own clock pair");
	serial_field_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.ctl_f |->
		eff_fmt[1] == st_reg.fmt_vec[22:20]
		&& eff_fmt[3] == st_reg.fmt_vec[42:40])
		else $error("Serial format field not applied");
	pin_capture_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		$rose(st_reg.run) |-> st_reg.pin_fmt == $past(st_reg.fp_f))
		else $error("Format pins not captured at release");
	pin_hold_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.run && $past(st_reg.run) |-> $stable(st_reg.pin_fmt))
		else $error("Captured pin format moved while running");
	pd_stretch_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		$fell(st_reg.pd_f) |=> !st_reg.run [*3])
		else $error("Receiver ran inside the power down stretch");
	pd_quiet_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!st_reg.run |=> o_sample_valid == 4'h0)
		else $error("Sample delivered while powered down");
	tdm_lanes_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		tdm_sync |-> lane_en[3:1] == 3'h0)
		else $error("Lanes 2-4 active during TDM");
	tdm_slot_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		o_sample_valid[0] && $past(tdm_sync, 2) && $past(tdm_sync)
		|-> o_sample_valid[3:1] == 3'h0)
		else $error("TDM sample seen outside lane one");
	apb_answer_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		apb_setup ##1 (apb_access && !i_pwrite) |->
		o_pready && o_prdata == $past(rd_word))
		else $error("Read data not the word chosen at setup");

	// ********************************************
	// Checks on format control and the bus
	// ********************************************
	// pins drive every converter
	par_common_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!st_reg.ctl_f |-> eff_fmt == {4{st_reg.pin_fmt}})
		else $error("Parallel format not common to all lanes");

	field_mask_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		(st_reg.fmt_vec & ~`SRCIN_FMT_MASK) == 48'h0000_0000_0000)
		else $error("Format vector holds bits outside the fields");

	bad_write_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		apb_access && !addr_hit && st_reg.pd_f |=>
		$stable(st_reg.fmt_vec))
		else $error("Unmapped write changed a format field");

	pd_clear_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!st_reg.pd_f |=> st_reg.fmt_vec == `SRCIN_FMT_RESET)
		else $error("Format fields kept through power down");

	async_lanes_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		st_reg.sel_f |-> lane_en == {4{st_reg.run}})
		else $error("Asynchronous lane switched off while running");

	pin_steady_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!st_reg.ctl_f && $stable(st_reg.ctl_f) && st_reg.run
		&& $past(st_reg.run) |-> $stable(eff_fmt))
		else $error("Parallel format moved while running");

	// Answer lines quiet outside the access phase
	bus_idle_a: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!apb_access |-> !o_pready && !o_pslverr)
		else $error("Bus answer outside an access phase");
endmodule

//--- verification/srcin_src_model.sv
// Behavioural audio source that drives one serial input lane
`timescale 1ns/1ns
module srcin_src_model #(
	parameter int OFS = 7
) (
	output logic o_bclk,
	output logic o_lrck,
	output logic o_sdata
);
	// ****************************************
	// Serial source
	// ****************************************
	// Idle: bit clock stands still between runs
	initial begin
		o_bclk = 1'b0;
		o_lrck = 1'b0;
		o_sdata = 1'b0;
	end

	// change before rise
	// Bit clock of 800 ns: 64 or 256 bits per frame, never above 256
	task automatic put_bit(input logic lr, input logic d);
		o_lrck = lr;
		o_sdata = d;
		#400 o_bclk = 1'b1;
		#400 o_bclk = 1'b0;
	endtask

	// word placement
	// Units of 32 bits: stereo halves or TDM slots
	task automatic run(input logic [2:0] fmt, input int n,
		input logic [7:0][23:0] w);
		int   u;
		int   p;
		int   nb;
		logic l0;
		logic i2s;
		i2s = (fmt == 3'h3) || (fmt >= 3'h6);
		u = (fmt >= 3'h5) ? 8 : 2;
		l0 = !i2s;
		nb = (fmt == 3'h0) ? 16 : (fmt == 3'h1) ? 20 : 24;
		p = i2s ? 1 : (fmt == 3'h2 || fmt == 3'h5) ? 0 : 32 - nb;
		#OFS;
		// Lead-in bit makes the first frame edge visible
		put_bit(~l0, 1'b0);
		for (int h = 0; h < n; h++) begin
			for (int i = 0; i < 32; i++) begin
				put_bit((h % u == 0) ? l0 : ~l0,
					(i >= p && i < p + nb) ? w[h][23 - (i - p)] : 1'b0);
			end
		end
		// Closing edge ends the last LSB-justified word
		put_bit(l0, 1'b0);
		// Released line shows the inverse of the last bit
		o_sdata = ~o_sdata;
	endtask
endmodule

//--- verification/test_srcin_top.sv
// Self-checking bench of the serial audio input port receiver
`timescale 1ns/1ns
`include "srcin_defs.svh"
module test_srcin_top;
	logic             i_clock;
	logic             i_resetn;
	logic             i_power_down_n;
	logic             i_sync_select;
	logic             i_control_select;
	logic [2:0]       i_format_pins;
	logic [3:0]       i_input_bit_clock;
	logic [3:0]       i_input_frame_clock;
	logic [3:0]       i_serial_data_in;
	logic             i_psel;
	logic             i_penable;
	logic             i_pwrite;
	logic [11:0]      i_paddr;
	logic [31:0]      i_pwdata;
	logic [31:0]      o_prdata;
	logic             o_pready;
	logic             o_pslverr;
	logic [3:0]       o_sample_valid;
	logic [3:0][23:0] o_sample_data;
	logic [3:0][2:0]  o_sample_tag;
	logic [3:0]       bclk_m;
	logic [3:0]       lrck_m;
	logic [3:0]       sd_m;
	logic             data_hi;
	logic [26:0]      got_q[4][$];
	int               failures = 0;
	int               tests_run = 0;
	int               cyc = 0;

	// ****************************************
	// Design, sources and pin routing
	// ****************************************
	srcin_top i_srcin_top (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_power_down_n(i_power_down_n), .i_sync_select(i_sync_select),
		.i_control_select(i_control_select),
		.i_format_pins(i_format_pins),
		.i_input_bit_clock(i_input_bit_clock),
		.i_input_frame_clock(i_input_frame_clock),
		.i_serial_data_in(i_serial_data_in), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_sample_valid(o_sample_valid),
		.o_sample_data(o_sample_data), .o_sample_tag(o_sample_tag));

	// Phase offsets keep the link edges off the system clock edges
	for (genvar g = 0; g < 4; g++) begin : g_src
		srcin_src_model #(.OFS(7 + 22 * g)) i_srcin_src_model (
			.o_bclk(bclk_m[g]), .o_lrck(lrck_m[g]), .o_sdata(sd_m[g]));
	end

	assign i_input_bit_clock = i_sync_select ? bclk_m : {3'h0, bclk_m[0]};
	assign i_input_frame_clock = i_sync_select ? lrck_m : {3'h0, lrck_m[0]};
	assign i_serial_data_in = data_hi ? {3'h7, sd_m[0]} : sd_m;

	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end

	// Sample collector and hang guard
	always @(posedge i_clock) begin
		for (int k = 0; k < 4; k++)
			if (o_sample_valid[k] === 1'b1)
				got_q[k].push_back({o_sample_tag[k], o_sample_data[k]});
		cyc++;
		if (cyc == 40000) begin
			failures++;
			close_out();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("Compares %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		// Ends once o_pready is high; otherwise only the bench timeout ends this wait
		do begin
			@(posedge i_clock);
		end while (o_pready !== 1'b1);
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clock);
	endtask

	// pins set in power down
	// Low for 200 ns, then wait for the running flag
	task automatic pd_cycle(input logic [2:0] pins);
		logic [31:0] r;
		logic        e;
		i_power_down_n <= 1'b0;
		i_format_pins <= pins;
		repeat (2) @(posedge i_clock);
		i_power_down_n <= 1'b1;
		do begin
			apb(1'b0, `SRCIN_ADDR_STATUS, 32'h0, r, e);
		end while (r[`SRCIN_ST_RUN] !== 1'b1);
	endtask

	// Negative test words (bit 23 set), distinct per lane and unit
	function automatic logic [23:0] word(input int k, input int h);
		word = 24'ha5c3e1 ^ (24'h111111 * h[23:0]) ^ (24'h0f0f07 * k[23:0]);
	endfunction

	task automatic go_all(input logic [3:0][2:0] f, input int n);
		logic [7:0][23:0] w[4];
		for (int k = 0; k < 4; k++) begin
			got_q[k].delete();
			for (int h = 0; h < 8; h++)
				w[k][h] = word(k, h);
		end
		fork
			g_src[0].i_srcin_src_model.run(f[0], n, w[0]);
			g_src[1].i_srcin_src_model.run(f[1], n, w[1]);
			g_src[2].i_srcin_src_model.run(f[2], n, w[2]);
			g_src[3].i_srcin_src_model.run(f[3], n, w[3]);
		join
		repeat (12) @(posedge i_clock);
	endtask

	// A stray word from the lead-in edge is tolerated ahead of the words
	task automatic chk_lane(input int k, input logic [2:0] f, input int n);
		logic [23:0] m;
		logic [2:0]  t;
		int          b;
		m = (f == 3'h0) ? 24'hffff00 : 24'hffffff;
		m = (f == 3'h1) ? 24'hfffff0 : m;
		b = got_q[k].size() - n;
		cmp(32'(b == 0 || b == 1), 32'h1);
		for (int h = 0; h < n && b >= 0; h++) begin
			t = (f >= 3'h5) ? 3'(h) : 3'(h % 2);
			cmp(32'(got_q[k][b + h]), {5'h0, t, word(k, h) & m});
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		i_control_select <= 1'b1;
		pd_cycle(3'h0);
		apb(1'b0, `SRCIN_ADDR_FMT_LO, 32'h0, r, e);
		cmp(r, 32'h0);
		apb(1'b1, `SRCIN_ADDR_FMT_LO, 32'hffffffff, r, e);
		apb(1'b1, `SRCIN_ADDR_FMT_HI, 32'hffffffff, r, e);
		apb(1'b0, `SRCIN_ADDR_FMT_LO, 32'h0, r, e);
		cmp(r, 32'hc0701c00);
		apb(1'b0, `SRCIN_ADDR_FMT_HI, 32'h0, r, e);
		cmp(r, 32'h00000701);
		apb(1'b1, `SRCIN_ADDR_STATUS, 32'h0, r, e);
		cmp({31'h0, e}, 32'h0);
		apb(1'b0, 12'h00c, 32'h0, r, e);
		cmp({r[30:0], e}, 32'h1);
		apb(1'b0, `SRCIN_ADDR_STATUS, 32'h0, r, e);
		cmp({31'h0, r[`SRCIN_ST_CTL]}, 32'h1);
		$display("register test done");
	endtask

	task automatic t_par();
		i_sync_select <= 1'b0;
		i_control_select <= 1'b0;
		for (int f = 0; f < 5; f++) begin
			pd_cycle(3'(f));
			i_format_pins <= ~3'(f);
			go_all({4{3'(f)}}, 8);
			for (int k = 0; k < 4; k++)
				chk_lane(k, 3'(f), 8);
		end
		$display("parallel synchronous test done");
	endtask

	task automatic t_tdm();
		data_hi <= 1'b1;
		for (int f = 5; f < 8; f++) begin
			pd_cycle(3'(f));
			go_all({4{3'(f)}}, 8);
			chk_lane(0, 3'(f), 8);
			for (int k = 1; k < 4; k++)
				cmp(got_q[k].size(), 32'h0);
		end
		data_hi <= 1'b0;
		$display("time division test done");
	endtask

	task automatic t_async();
		logic [3:0][2:0] fa;
		logic [47:0]     v;
		logic [31:0]     r;
		logic            e;
		fa = {3'h4, 3'h3, 3'h1, 3'h0};
		v = 48'h0;
		for (int k = 0; k < 4; k++)
			v[10 * (k + 1) +: 3] = fa[k];
		i_sync_select <= 1'b1;
		i_control_select <= 1'b1;
		pd_cycle(3'h2);
		apb(1'b1, `SRCIN_ADDR_FMT_LO, v[31:0], r, e);
		apb(1'b1, `SRCIN_ADDR_FMT_HI, {16'h0, v[47:32]}, r, e);
		go_all(fa, 8);
		for (int k = 0; k < 4; k++)
			chk_lane(k, fa[k], 8);
		$display("asynchronous test done");
	endtask

	task automatic t_pd();
		logic [31:0] r;
		logic        e;
		pd_cycle(3'h2);
		apb(1'b0, `SRCIN_ADDR_FMT_LO, 32'h0, r, e);
		cmp(r, 32'h0);
		i_power_down_n <= 1'b0;
		go_all({4{3'h2}}, 2);
		for (int k = 0; k < 4; k++)
			cmp(got_q[k].size(), 32'h0);
		i_power_down_n <= 1'b1;
		$display("power down test done");
	endtask

	initial begin
		i_resetn = 1'b0;
		i_power_down_n = 1'b0;
		i_sync_select = 1'b0;
		i_control_select = 1'b0;
		i_format_pins = 3'h0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		data_hi = 1'b0;
		repeat (6) @(posedge i_clock);
		i_resetn <= 1'b1;
		@(posedge i_clock);
		t_regs();
		t_par();
		t_tdm();
		t_async();
		t_pd();
		close_out();
	end
endmodule
